/* File: shared/cce_regs.svh */
// register offsets, field positions and fixed values of the command executor
`ifndef CCE_REGS_SVH
`define CCE_REGS_SVH
`define CCE_OFF_CMD      8'h00
`define CCE_OFF_OUTQ     8'h04
`define CCE_OFF_STB      8'h08
`define CCE_OFF_SRE      8'h0C
`define CCE_OFF_ESR      8'h10
`define CCE_OFF_SETUP    8'h14
`define CCE_OFF_STAT     8'h18
`define CCE_OFF_ARM      8'h1C
`define CCE_STB_MAV      4
`define CCE_STB_RQS      6
`define CCE_SRE_MAV      4
`define CCE_ESR_OPC      0
`define CCE_SETUP_PRESET 32'h00000001
`define CCE_ASCII_ONE    32'h00000031
`define CCE_ASCII_COMMA  32'h0000002C
`define CCE_ASCII_NONE   32'h4E4F4E45
`define CCE_SLOT_MAX     4'h3
`define CCE_ROM_SUM      8'h64
`define CCE_RESP_OKAY    2'h0
`define CCE_RESP_SLVERR  2'h2
`endif

/* File: shared/cce_pkg.sv */
// types of the common command executor
package cce_pkg;
    typedef enum logic [7:0] {
        CCE_NOP      = 8'h00,
        CCE_OPC      = 8'h01,
        CCE_OPCQ     = 8'h02,
        CCE_OPTQ     = 8'h03,
        CCE_SAV      = 8'h04,
        CCE_RCL      = 8'h05,
        CCE_RST      = 8'h06,
        CCE_TRG      = 8'h07,
        CCE_TSTQ     = 8'h08,
        CCE_WAI      = 8'h09,
        CCE_INIT     = 8'h0A,
        CCE_INITC    = 8'h0B,
        CCE_INITC_OFF = 8'h0C
    } cce_op_t;
    typedef struct packed {
        logic [3:0] prm;
        cce_op_t    op;
    } cce_cmd_t;
    typedef enum logic [2:0] {
        S_FETCH = 3'b000,
        S_EXEC  = 3'b001,
        S_OPCQ  = 3'b010,
        S_OPT   = 3'b011,
        S_TST   = 3'b100,
        S_TSTR  = 3'b101,
        S_WAI   = 3'b110
    } cce_state_t;
endpackage

/* File: src/cce_top.sv */
// common command executor with AXI4-Lite register access
// Operation
// - OPC query queues ASCII one only after last pending operation finishes
// - a queued response sets message-available bit four of status byte
// - message-available with enable bit four set raises request-for-service bit
// - after initiate, completion waits until measurement returns to idle
// - OPC query keeps executing until its one is in the output queue
// - option query returns slot model, or NONE, comma separated
// - save and recall take location 0 to 3, four setups
// - save holds all reset-affected settings; recall restores them (here only the setup word; arm source and continuous initiate are not saved)
// - failed recall falls back to preset values
// - reset restores defaults, cancels pending commands and OPC responses
// - trigger command acts exactly like a bus group execute trigger
// - bus trigger honoured only when arm source is bus
// - self-test checksums ROM and queues 0 pass, 1 fail
// - queued responses leave only while host addresses device to talk
// - sequential command finishes before the next starts
// - only initiate, continuous initiate on and trigger overlap
// - wait-to-continue holds later commands until overlapped operations end
// - after trigger, waiting lasts until trigger pointer settles
// - OPC command sets event bit zero once pending work completes
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "cce_regs.svh"
module cce_top import cce_pkg::*; #(
    parameter int CQ_DEPTH = 4,
    parameter int OQ_DEPTH = 8
) (
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic [7:0]  S_AXI_AWADDR,
    input  wire logic        S_AXI_AWVALID,
    output logic             S_AXI_AWREADY,
    input  wire logic [31:0] S_AXI_WDATA,
    input  wire logic [3:0]  S_AXI_WSTRB,
    input  wire logic        S_AXI_WVALID,
    output logic             S_AXI_WREADY,
    output logic [1:0]       S_AXI_BRESP,
    output logic             S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic [7:0]  S_AXI_ARADDR,
    input  wire logic        S_AXI_ARVALID,
    output logic             S_AXI_ARREADY,
    output logic [31:0]      S_AXI_RDATA,
    output logic [1:0]       S_AXI_RRESP,
    output logic             S_AXI_RVALID,
    input  wire logic        S_AXI_RREADY,
    input  wire logic        MEAS_IDLE,
    input  wire logic        TRIG_SETTLED,
    input  wire logic        GET_IN,
    input  wire logic        TALK,
    input  wire logic [31:0] SLOT0_MODEL,
    input  wire logic [31:0] SLOT1_MODEL,
    output logic             TRIG_OUT,
    output logic             INIT_OUT
);
    localparam int CW = $clog2(CQ_DEPTH);
    localparam int OW = $clog2(OQ_DEPTH);
    localparam logic [7:0] ROM [8] = '{8'h11, 8'h22, 8'h33, 8'h44,
                                       8'h55, 8'h66, 8'h77, 8'h88};

    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        wr_en;
    logic        wr_map;
    logic        rd_en;
    logic        rd_map;
    logic [31:0] next_rdata;
    logic [3:0]  sync_m;
    logic [3:0]  sync_s;
    logic        get_d;
    logic        idle_s;
    logic        settled_s;
    logic        talk_s;
    logic        get_rise;
    cce_cmd_t    cq [CQ_DEPTH];
    logic [CW-1:0] cq_head;
    logic [CW-1:0] cq_tail;
    logic [CW:0] cq_cnt;
    logic [31:0] oq [OQ_DEPTH];
    logic [OW-1:0] oq_head;
    logic [OW-1:0] oq_tail;
    logic [OW:0] oq_cnt;
    logic        oq_push;
    logic        oq_pop;
    logic [31:0] oq_wdata;
    cce_state_t  state;
    cce_cmd_t    cur;
    logic [2:0]  step;
    logic [7:0]  tst_sum;
    logic        tst_fail;
    logic        exec;
    logic        wr_cmd;
    logic        rst_cmd;
    logic        cq_push;
    logic        cq_pop;
    logic        trig_evt;
    logic        init_pend;
    logic        seen_busy;
    logic        trg_pend;
    logic        trg_moved;
    logic        cont_on;
    logic        opc_armed;
    logic        pending;
    logic        mav;
    logic        rqs;
    logic [7:0]  stb;
    logic [7:0]  sre;
    logic [7:0]  esr;
    logic        arm_bus;
    logic [31:0] setup;
    logic [31:0] slot_mem [4];
    logic [3:0]  slot_ok;
    logic        rcl_err;
    logic [31:0] stat;

    ////////////////////////////////////////////////////////////////////////
    // bus slave: address and data taken in either order
    assign wr_en = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
    assign wr_map = (aw_addr == `CCE_OFF_CMD) || (aw_addr == `CCE_OFF_SRE)
                 || (aw_addr == `CCE_OFF_ESR) || (aw_addr == `CCE_OFF_SETUP)
                 || (aw_addr == `CCE_OFF_ARM);
    assign rd_en = S_AXI_ARVALID && S_AXI_ARREADY;
    assign rd_map = (S_AXI_ARADDR[7:5] == 3'h0) && (S_AXI_ARADDR[1:0] == 2'h0);

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= `CCE_RESP_OKAY;
            aw_addr       <= 8'h00;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
        end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_addr       <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_data       <= S_AXI_WDATA;
                w_strb       <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_en) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (wr_map && w_strb == 4'hF) ? `CCE_RESP_OKAY
                                                          : `CCE_RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID  <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY  <= 1'b1;
            end
        end
    end

    always_comb begin
        next_rdata = 32'h00000000;
        if (S_AXI_ARADDR == `CCE_OFF_OUTQ) begin
            if (talk_s && oq_cnt != '0) next_rdata = oq[oq_head];
        end else if (S_AXI_ARADDR == `CCE_OFF_STB) begin
            next_rdata = {24'h000000, stb};
        end else if (S_AXI_ARADDR == `CCE_OFF_SRE) begin
            next_rdata = {24'h000000, sre};
        end else if (S_AXI_ARADDR == `CCE_OFF_ESR) begin
            next_rdata = {24'h000000, esr};
        end else if (S_AXI_ARADDR == `CCE_OFF_SETUP) begin
            next_rdata = setup;
        end else if (S_AXI_ARADDR == `CCE_OFF_STAT) begin
            next_rdata = stat;
        end else if (S_AXI_ARADDR == `CCE_OFF_ARM) begin
            next_rdata = {31'h00000000, arm_bus};
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h00000000;
            S_AXI_RRESP   <= `CCE_RESP_OKAY;
        end else if (rd_en) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= next_rdata;
            S_AXI_RRESP   <= rd_map ? `CCE_RESP_OKAY : `CCE_RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID  <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync_m <= 4'h0;
            sync_s <= 4'h0;
            get_d  <= 1'b0;
        end else begin
            sync_m <= {MEAS_IDLE, TRIG_SETTLED, GET_IN, TALK};
            sync_s <= sync_m;
            get_d  <= sync_s[1];
        end
    end
    assign idle_s    = sync_s[3];
    assign settled_s = sync_s[2];
    assign talk_s    = sync_s[0];
    assign get_rise  = sync_s[1] && !get_d;

    ////////////////////////////////////////////////////////////////////////
    // command queue; held commands keep arriving while execution waits
    assign wr_cmd  = wr_en && aw_addr == `CCE_OFF_CMD && w_strb == 4'hF;
    // reset bypasses the queue, otherwise a held wait could never be broken
    assign rst_cmd = wr_cmd && w_data[7:0] == CCE_RST;
    assign cq_push = wr_cmd && !rst_cmd && cq_cnt != (CW+1)'(CQ_DEPTH);
    assign cq_pop  = state == S_FETCH && cq_cnt != '0;

    always_ff @(posedge CLOCK) begin
        if (cq_push) cq[cq_tail] <= cce_cmd_t'(w_data[11:0]);
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cq_head <= '0;
            cq_tail <= '0;
            cq_cnt  <= '0;
        end else if (rst_cmd) begin
            cq_head <= '0;
            cq_tail <= '0;
            cq_cnt  <= '0;
        end else begin
            if (cq_push) cq_tail <= CW'(cq_tail + 1'b1);
            if (cq_pop) cq_head <= CW'(cq_head + 1'b1);
            cq_cnt <= (CW+1)'(cq_cnt + cq_push - cq_pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output queue, drained only while talk is addressed
    assign oq_pop = rd_en && S_AXI_ARADDR == `CCE_OFF_OUTQ && talk_s
                 && oq_cnt != '0;

    always_ff @(posedge CLOCK) begin
        if (oq_push) oq[oq_tail] <= oq_wdata;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            oq_head <= '0;
            oq_tail <= '0;
            oq_cnt  <= '0;
        end else begin
            if (oq_push) oq_tail <= OW'(oq_tail + 1'b1);
            if (oq_pop) oq_head <= OW'(oq_head + 1'b1);
            oq_cnt <= (OW+1)'(oq_cnt + oq_push - oq_pop);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: one command at a time, sequential ones run to the end
    assign exec    = state == S_EXEC;
    assign pending = init_pend || trg_pend;

    always_comb begin
        oq_push  = 1'b0;
        oq_wdata = `CCE_ASCII_ONE;
        if (state == S_OPCQ) begin
            oq_push = !pending && oq_cnt != (OW+1)'(OQ_DEPTH);
        end else if (state == S_OPT) begin
            oq_push = oq_cnt != (OW+1)'(OQ_DEPTH);
            if (step == 3'h1) begin
                oq_wdata = `CCE_ASCII_COMMA;
            end else if (step == 3'h0) begin
                oq_wdata = (SLOT0_MODEL == '0) ? `CCE_ASCII_NONE : SLOT0_MODEL;
            end else begin
                oq_wdata = (SLOT1_MODEL == '0) ? `CCE_ASCII_NONE : SLOT1_MODEL;
            end
        end else if (state == S_TSTR) begin
            oq_push  = oq_cnt != (OW+1)'(OQ_DEPTH);
            oq_wdata = {31'h00000000, tst_sum != `CCE_ROM_SUM};
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state    <= S_FETCH;
            cur      <= '{prm: 4'h0, op: CCE_NOP};
            step     <= 3'h0;
            tst_sum  <= 8'h00;
            tst_fail <= 1'b0;
        end else if (rst_cmd) begin
            state <= S_FETCH;
        end else begin
            case (state)
                S_FETCH: begin
                    if (cq_pop) begin
                        cur   <= cq[cq_head];
                        state <= S_EXEC;
                    end
                end
                S_EXEC: begin
                    step    <= 3'h0;
                    tst_sum <= 8'h00;
                    case (cur.op)
                        CCE_OPCQ: state <= S_OPCQ;
                        CCE_OPTQ: state <= S_OPT;
                        CCE_TSTQ: state <= S_TST;
                        CCE_WAI:  state <= S_WAI;
                        default:  state <= S_FETCH;
                    endcase
                end
                S_OPCQ: begin
                    if (oq_push) state <= S_FETCH;
                end
                S_OPT: begin
                    if (oq_push) begin
                        step <= 3'(step + 1'b1);
                        if (step == 3'h2) state <= S_FETCH;
                    end
                end
                S_TST: begin
                    tst_sum <= 8'(tst_sum + ROM[step]);
                    step    <= 3'(step + 1'b1);
                    if (step == 3'h7) state <= S_TSTR;
                end
                S_TSTR: begin
                    if (oq_push) begin
                        tst_fail <= oq_wdata[0];
                        state    <= S_FETCH;
                    end
                end
                S_WAI: begin
                    if (!pending) state <= S_FETCH;
                end
                default: state <= S_FETCH;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // overlapped operations and completion tracking
    // trigger command and bus trigger share one path
    assign trig_evt = (exec && cur.op == CCE_TRG) || get_rise;

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            init_pend <= 1'b0;
            seen_busy <= 1'b0;
            trg_pend  <= 1'b0;
            trg_moved <= 1'b0;
            cont_on   <= 1'b0;
            opc_armed <= 1'b0;
        end else if (rst_cmd) begin
            init_pend <= 1'b0;
            seen_busy <= 1'b0;
            trg_pend  <= 1'b0;
            trg_moved <= 1'b0;
            cont_on   <= 1'b0;
            opc_armed <= 1'b0;
        end else begin
            if (exec && (cur.op == CCE_INIT || cur.op == CCE_INITC)) begin
                init_pend <= 1'b1;
                seen_busy <= 1'b0;
            end else if (init_pend && !idle_s) begin
                seen_busy <= 1'b1;
            end else if (init_pend && seen_busy && !cont_on) begin
                init_pend <= 1'b0;
            end
            if (exec && cur.op == CCE_INITC) cont_on <= 1'b1;
            else if (exec && cur.op == CCE_INITC_OFF) cont_on <= 1'b0;
            // set wins so a fresh trigger is never lost
            // settled pin lags the pulse, so the pointer must be seen moving first
            if (trig_evt && arm_bus) begin
                trg_pend  <= 1'b1;
                trg_moved <= 1'b0;
            end else if (trg_pend && !settled_s) begin
                trg_moved <= 1'b1;
            end else if (trg_pend && trg_moved) begin
                trg_pend  <= 1'b0;
            end
            if (exec && cur.op == CCE_OPC) opc_armed <= 1'b1;
            else if (!pending) opc_armed <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            TRIG_OUT <= 1'b0;
            INIT_OUT <= 1'b0;
        end else begin
            TRIG_OUT <= trig_evt && arm_bus && !rst_cmd;
            INIT_OUT <= exec && !rst_cmd
                     && (cur.op == CCE_INIT || cur.op == CCE_INITC);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status byte and event register
    assign mav = oq_cnt != '0;
    assign rqs = mav && sre[`CCE_SRE_MAV];
    always_comb begin
        stb = 8'h00;
        stb[`CCE_STB_MAV] = mav;
        stb[`CCE_STB_RQS] = rqs;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sre     <= 8'h00;
            esr     <= 8'h00;
            arm_bus <= 1'b0;
        end else begin
            if (wr_en && aw_addr == `CCE_OFF_SRE && w_strb == 4'hF) sre <= w_data[7:0];
            if (rst_cmd) arm_bus <= 1'b0;
            else if (wr_en && aw_addr == `CCE_OFF_ARM && w_strb == 4'hF) arm_bus <= w_data[0];
            // write one to clear; completion in the same cycle wins
            if (opc_armed && !pending && !rst_cmd) esr[`CCE_ESR_OPC] <= 1'b1;
            else if (wr_en && aw_addr == `CCE_OFF_ESR && w_strb == 4'hF)
                esr <= esr & ~w_data[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // setup word and four saved copies
    always_ff @(posedge CLOCK) begin
        if (exec && cur.op == CCE_SAV && cur.prm <= `CCE_SLOT_MAX)
            slot_mem[cur.prm[1:0]] <= setup;
    end

    always_ff @(posedge CLOCK or posedge SYS_RST) begin
        if (SYS_RST) begin
            setup   <= `CCE_SETUP_PRESET;
            slot_ok <= 4'h0;
            rcl_err <= 1'b0;
        end else if (rst_cmd) begin
            setup <= `CCE_SETUP_PRESET;
        end else if (exec && cur.op == CCE_SAV && cur.prm <= `CCE_SLOT_MAX) begin
            slot_ok[cur.prm[1:0]] <= 1'b1;
        end else if (exec && cur.op == CCE_RCL) begin
            if (cur.prm <= `CCE_SLOT_MAX && slot_ok[cur.prm[1:0]]) begin
                setup   <= slot_mem[cur.prm[1:0]];
                rcl_err <= 1'b0;
            end else begin
                setup   <= `CCE_SETUP_PRESET;
                rcl_err <= 1'b1;
            end
        end else if (wr_en && aw_addr == `CCE_OFF_SETUP && w_strb == 4'hF) begin
            setup <= w_data;
        end
    end

    always_comb begin
        stat = 32'h00000000;
        stat[3:0]   = 4'(cq_cnt);
        stat[7:4]   = 4'(oq_cnt);
        stat[10:8]  = state;
        stat[11]    = pending;
        stat[12]    = cont_on;
        stat[13]    = opc_armed;
        stat[14]    = rcl_err;
        stat[15]    = tst_fail;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_opc_one;
        @(posedge CLOCK) disable iff (SYS_RST)
        (state == S_OPCQ && oq_push) |-> !pending;
    endproperty
    a_opc_one: assert property (p_opc_one) else $error("one queued early");

    property p_mav;
        @(posedge CLOCK) disable iff (SYS_RST)
        (oq_push && !oq_pop) |=> stb[`CCE_STB_MAV];
    endproperty
    a_mav: assert property (p_mav) else $error("mav not set");

    property p_rqs;
        @(posedge CLOCK) disable iff (SYS_RST)
        stb[`CCE_STB_RQS] == (oq_cnt != '0 && sre[`CCE_SRE_MAV]);
    endproperty
    a_rqs: assert property (p_rqs) else $error("rqs wrong");

    property p_opcq_hold;
        @(posedge CLOCK) disable iff (SYS_RST)
        (state == S_OPCQ && pending && !rst_cmd) |=> state == S_OPCQ;
    endproperty
    a_opcq_hold: assert property (p_opcq_hold) else $error("opc left early");

    property p_rcl_fail;
        @(posedge CLOCK) disable iff (SYS_RST)
        (exec && cur.op == CCE_RCL && !rst_cmd
         && (cur.prm > `CCE_SLOT_MAX || !slot_ok[cur.prm[1:0]]))
        |=> setup == `CCE_SETUP_PRESET && rcl_err;
    endproperty
    a_rcl_fail: assert property (p_rcl_fail) else $error("recall fallback");

    property p_rst;
        @(posedge CLOCK) disable iff (SYS_RST)
        rst_cmd |=> cq_cnt == '0 && !opc_armed && state == S_FETCH
                 && !pending ##1 !esr[`CCE_ESR_OPC] || $past(esr[`CCE_ESR_OPC]);
    endproperty
    a_rst: assert property (p_rst) else $error("reset incomplete");

    property p_arm;
        @(posedge CLOCK) disable iff (SYS_RST)
        (trig_evt && !arm_bus) |=> !TRIG_OUT;
    endproperty
    a_arm: assert property (p_arm) else $error("trigger not gated");

    property p_talk;
        @(posedge CLOCK) disable iff (SYS_RST)
        (rd_en && S_AXI_ARADDR == `CCE_OFF_OUTQ && !talk_s)
        |=> S_AXI_RDATA == 32'h00000000 && $stable(oq_head);
    endproperty
    a_talk: assert property (p_talk) else $error("pop without talk");

    property p_wai;
        @(posedge CLOCK) disable iff (SYS_RST)
        (state == S_WAI && pending && !rst_cmd) |=> state == S_WAI && !cq_pop;
    endproperty
    a_wai: assert property (p_wai) else $error("wait released");

    property p_opc_bit;
        @(posedge CLOCK) disable iff (SYS_RST)
        (opc_armed && !pending && !rst_cmd) |=> esr[`CCE_ESR_OPC] && !opc_armed;
    endproperty
    a_opc_bit: assert property (p_opc_bit) else $error("opc bit missing");

    c_opcq: cover property (@(posedge CLOCK) state == S_OPCQ && oq_push);
    c_wai: cover property (@(posedge CLOCK) state == S_WAI ##1 state == S_FETCH);
    c_opt: cover property (@(posedge CLOCK) state == S_OPT && step == 3'h2 && oq_push);
    c_tst: cover property (@(posedge CLOCK) state == S_TSTR && oq_push);
endmodule

/* File: bench/cce_far.sv */
// far-side model: measurement system and trigger pointer
`timescale 1ns/100ps
module cce_far #(
    parameter int BUSY = 40
) (
    input  wire logic clk,
    input  wire logic init_pulse,
    input  wire logic trig_pulse,
    output logic      idle,
    output logic      settled
);
    int mc = 0;
    int tc = 0;
    // busy spans well past the executor's pin synchronisers
    always_ff @(posedge clk) mc <= init_pulse ? BUSY : (mc > 0 ? mc - 1 : 0);
    always_ff @(posedge clk) tc <= trig_pulse ? BUSY : (tc > 0 ? tc - 1 : 0);
    assign idle    = (mc == 0);
    assign settled = (tc == 0);
endmodule

/* File: bench/cce_top_bench.sv */
// self-checking bench for the common command executor
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module cce_top_bench;
    logic        clk = 0, rst = 1, awv = 0, wv = 0, bry = 1, arv = 0, rry = 1;
    logic [1:0]  brsp, rrsp, lb, lr;
    logic        get = 0, talk = 0, awy, wy, bv, ary, rv, trg, ini, idle, setl;
    logic [7:0]  awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat;
    int          bad_count = 0, compares = 0, trigs = 0, inits = 0;
    cce_top u_dut (.CLOCK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wy), .S_AXI_BRESP(brsp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ary), .S_AXI_RDATA(rdat),
        .S_AXI_RRESP(rrsp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .MEAS_IDLE(idle),
        .TRIG_SETTLED(setl), .GET_IN(get), .TALK(talk), .SLOT0_MODEL(32'h41424344),
        .SLOT1_MODEL(32'h0), .TRIG_OUT(trg), .INIT_OUT(ini));
    cce_far #(.BUSY(40)) u_far (.clk(clk), .init_pulse(ini), .trig_pulse(trg),
        .idle(idle), .settled(setl));
    initial begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) if (trg === 1'b1) trigs <= trigs + 1;
    always @(posedge clk) if (ini === 1'b1) inits <= inits + 1;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        forever begin
            @(posedge clk);
            if (awy) awv <= 1'b0;
            if (wy) wv <= 1'b0;
            if (bv === 1'b1) break;
        end
        lb = brsp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ara <= a;
        arv <= 1'b1;
        forever begin
            @(posedge clk);
            if (ary) arv <= 1'b0;
            if (rv === 1'b1) break;
        end
        d = rdat;
        lr = rrsp;
    endtask
    task automatic ck(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        `CHK(v, e)
    endtask
    // polls message-available; bounded so a stuck queue ends the wait
    task automatic pw;
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < 100 && v[4] !== 1'b1; i++) rd(8'h08, v);
    endtask
    task automatic close_out;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        ck(8'h14, 32'h1);
        `CHK(lr, 2'h0)
        ck(8'h40, 32'h0);
        `CHK(lr, 2'h2)
        wr(8'h40, 32'h0);
        `CHK(lb, 2'h2)
        wr(8'h0C, 32'h10);
        `CHK(lb, 2'h0)
        wr(8'h00, 32'h8);
        pw();
        ck(8'h08, 32'h50);
        ck(8'h04, 32'h0);
        ck(8'h08, 32'h50);
        talk <= 1'b1;
        repeat (3) @(posedge clk);
        ck(8'h04, 32'h0);
        ck(8'h08, 32'h0);
        wr(8'h14, 32'hA5);
        wr(8'h00, 32'h204);
        wr(8'h14, 32'h0);
        wr(8'h1C, 32'h1);
        wr(8'h00, 32'h6);
        ck(8'h1C, 32'h0);
        wr(8'h00, 32'h205);
        wr(8'h00, 32'h2);
        pw();
        ck(8'h04, 32'h31);
        ck(8'h14, 32'hA5);
        wr(8'h00, 32'h305);
        wr(8'h00, 32'h2);
        pw();
        ck(8'h04, 32'h31);
        ck(8'h14, 32'h1);
        wr(8'h00, 32'hA);
        wr(8'h00, 32'h1);
        wr(8'h00, 32'h9);
        wr(8'h00, 32'h2);
        wr(8'h00, 32'h3);
        ck(8'h10, 32'h0);
        ck(8'h08, 32'h0);
        pw();
        ck(8'h04, 32'h31);
        ck(8'h04, 32'h41424344);
        ck(8'h04, 32'h2C);
        ck(8'h04, 32'h4E4F4E45);
        ck(8'h10, 32'h1);
        wr(8'h10, 32'h1);
        ck(8'h10, 32'h0);
        wr(8'h00, 32'hB);
        repeat (60) @(posedge clk);
        ck(8'h18, 32'h5800);
        wr(8'h00, 32'hC);
        wr(8'h00, 32'h2);
        pw();
        ck(8'h04, 32'h31);
        wr(8'h00, 32'h7);
        wr(8'h1C, 32'h1);
        wr(8'h00, 32'h7);
        wr(8'h00, 32'h9);
        wr(8'h00, 32'h2);
        ck(8'h08, 32'h0);
        pw();
        ck(8'h04, 32'h31);
        `CHK(trigs, 1)
        get <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(trigs, 2)
        `CHK(inits, 2)
        close_out();
    end
endmodule
